//--- hw/dmc_pkg.sv
// Constants, register map and state type of the two-channel DMA block.
// Assumes an APB master on the register side and a shared 16-bit bus.
package dmc_pkg;

   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int NCH   = 2;
   localparam int AW    = 20;
   localparam int SEL_W = 4;

   // ****************************************************************
   // Register offsets within one channel window
   // ****************************************************************
   localparam logic [4:0] OFS_SRC  = 5'h00;
   localparam logic [4:0] OFS_DST  = 5'h04;
   localparam logic [4:0] OFS_RLD  = 5'h08;
   localparam logic [4:0] OFS_CTRL = 5'h0C;
   localparam logic [4:0] OFS_CNT  = 5'h10;
   localparam logic [4:0] OFS_PTR  = 5'h14;
   localparam int         CH_BIT   = 5;

   // ****************************************************************
   // Control word fields
   // ****************************************************************
   localparam int CT_EN     = 0;
   localparam int CT_UNIT8  = 1;
   localparam int CT_FWDDST = 2;
   localparam int CT_REQ    = 3;
   localparam int CT_SWREQ  = 4;
   localparam int CT_SEL    = 8;

   // ****************************************************************
   // Request source codes
   // ****************************************************************
   localparam logic [3:0] SRC_PIN     = 4'h0;
   localparam logic [3:0] SRC_SW      = 4'h1;
   localparam logic [3:0] SRC_PERIPH0 = 4'h2;

   // ****************************************************************
   // Reset values and steps
   // ****************************************************************
   localparam logic [19:0] PTR_RST  = 20'h00000;
   localparam logic [15:0] CNT_RST  = 16'h0000;
   localparam logic [3:0]  SEL_RST  = 4'h0;
   localparam logic        PIN_IDLE = 1'b1;
   localparam logic [19:0] INC8     = 20'h00001;
   localparam logic [19:0] INC16    = 20'h00002;

   typedef enum logic [2:0] {
      S_IDLE, S_RD, S_RD2, S_WR, S_WR2, S_DUMMY, S_CPU
   } dmc_state_e;

endpackage

//--- hw/dmc_top.sv
// Two-channel DMA engine with APB registers and a 16-bit bus master port.
// Assumes the CPU takes one bus access (cpu_done) whenever the bus is handed
// back, and bus_slow flags waited memory or the special function area.
//
// Functional notes
// - Each unit is source read cycles followed by destination writes.
// - Odd 16-bit start costs two reads or two writes; else one each.
// - Waited memory or special function area adds one clock per cycle.
// - Unit length is reads times j plus writes times k.
// - Any mix of even and odd source and destination addresses works.
// - Enable write of one reloads forward pointer at next transfer.
// - Same first transfer reloads counter from the reload register.
// - Writing one to an active channel repeats both reloads.
// - Request bit sets on its source, enabled or not.
// - Request bit clears just before the transfer starts.
// - Software may clear the request bit; writing one does nothing.
// - Peripheral sources set request together with their event.
// - Pin source sets request on the selected pin edge.
// - Requests in one sampling period set all channels together.
// - Channel zero first, then one CPU access, then channel one.
// - Software request bit raises request; always reads as zero.
// - Transfers ignore CPU interrupt enable and priority levels.
`timescale 1ns/1ns
module dmc_top
   import dmc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [1:0]  external_interrupt_pin,
   input  wire logic [13:0] periph_evt,
   input  wire logic [15:0] bus_rdata,
   input  wire logic        bus_slow,
   input  wire logic        cpu_done,
   output logic             bus_own,
   output logic      [19:0] bus_addr,
   output logic             bus_rd,
   output logic             bus_wr,
   output logic             bus_byte,
   output logic      [15:0] bus_wdata
);

   // ****************************************************************
   // Decode helpers
   // ****************************************************************
   function automatic logic wsel(input logic [7:0] a, input logic c,
                                 input logic [4:0] o);
      return a[CH_BIT] == c && a[4:0] == o && a[7:6] == 2'h0;
   endfunction

   function automatic logic src_hit(input logic [3:0]  s,
                                    input logic        pf,
                                    input logic        sw,
                                    input logic [13:0] pe);
      if (s == SRC_PIN)
         return pf;
      if (s == SRC_SW)
         return sw;
      return pe[4'(s - SRC_PERIPH0)];
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   logic [19:0]    src_r [NCH];
   logic [19:0]    dst_r [NCH];
   logic [19:0]    ptr   [NCH];
   logic [15:0]    rld   [NCH];
   logic [15:0]    cnt   [NCH];
   logic [3:0]     sel   [NCH];
   logic [NCH-1:0] en;
   logic [NCH-1:0] unit8;
   logic [NCH-1:0] fwd_dst;
   logic [NCH-1:0] req;
   logic [NCH-1:0] fresh;
   logic [NCH-1:0] pin_q;
   logic [NCH-1:0] hit;
   dmc_state_e     state;
   dmc_state_e     next_state;
   logic           ch;
   logic           wt;
   logic [15:0]    data;
   logic [19:0]    w_src;
   logic [19:0]    w_dst;
   logic           w_unit8;
   logic [19:0]    next_addr;
   logic [15:0]    next_wdata;
   logic [31:0]    rmux;

   // ****************************************************************
   // APB slave
   // ****************************************************************
   wire        wr_acc = psel & penable & pwrite;
   wire        chs    = paddr[CH_BIT];
   wire        ok     = paddr[7:6] == 2'h0 && paddr[1:0] == 2'h0 &&
                        paddr[4:0] <= OFS_PTR;

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~ok;

   always_comb begin
      rmux = 32'h00000000;
      case (paddr[4:0])
         OFS_SRC:  rmux[19:0] = src_r[chs];
         OFS_DST:  rmux[19:0] = dst_r[chs];
         OFS_RLD:  rmux[15:0] = rld[chs];
         OFS_CNT:  rmux[15:0] = cnt[chs];
         OFS_PTR:  rmux[19:0] = ptr[chs];
         OFS_CTRL: begin
            rmux[CT_EN]     = en[chs];
            rmux[CT_UNIT8]  = unit8[chs];
            rmux[CT_FWDDST] = fwd_dst[chs];
            rmux[CT_REQ]    = req[chs];
            rmux[CT_SEL+:SEL_W] = sel[chs];
         end
         default: rmux = 32'h00000000;
      endcase
      if (!ok)
         rmux = 32'h00000000;
   end

   // Read data is caught in the setup cycle so prdata comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (psel & ~penable & ~pwrite)
         prdata <= rmux;
   end

   // ****************************************************************
   // Channel selection and start values
   // ****************************************************************
   // No interrupt enable or level input exists on purpose
   wire [NCH-1:0] go    = en & req;
   wire           pick  = ~go[0];
   wire           start = state == S_IDLE && |go;
   wire [19:0]    base_p = fresh[pick] ?
                           (fwd_dst[pick] ? dst_r[pick] : src_r[pick]) :
                           ptr[pick];
   wire [19:0]    st_src = fwd_dst[pick] ? src_r[pick] : base_p;
   wire [19:0]    st_dst = fwd_dst[pick] ? base_p : dst_r[pick];
   wire           idle   = state == S_IDLE;
   wire [19:0]    a_src  = idle ? st_src : w_src;
   wire [19:0]    a_dst  = idle ? st_dst : w_dst;
   wire           a_u8   = idle ? unit8[pick] : w_unit8;
   wire           src2   = ~a_u8 & a_src[0];
   wire           dst2   = ~a_u8 & a_dst[0];
   wire           busy   = state inside {S_RD, S_RD2, S_WR, S_WR2};
   wire           adv    = ~(bus_slow & ~wt);
   wire [15:0]    rd_word = state == S_RD2 ?
                            {bus_rdata[7:0], data[7:0]} : bus_rdata;

   // ****************************************************************
   // Per-channel registers and request flags
   // ****************************************************************
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      wire wctl  = wr_acc & wsel(paddr, 1'(c), OFS_CTRL);
      wire sw_c  = wctl & pwdata[CT_SWREQ];
      wire pfall = pin_q[c] & ~external_interrupt_pin[c];
      wire take  = start & (pick == 1'(c));
      wire fin   = state == S_DUMMY && ch == 1'(c);

      // Peripheral pulses arrive in step with their own interrupt flags
      assign hit[c] = src_hit(sel[c], pfall, sw_c, periph_evt);

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pin_q[c]   <= PIN_IDLE;
            req[c]     <= 1'b0;
            en[c]      <= 1'b0;
            fresh[c]   <= 1'b0;
            unit8[c]   <= 1'b0;
            fwd_dst[c] <= 1'b0;
            sel[c]     <= SEL_RST;
            src_r[c]   <= PTR_RST;
            dst_r[c]   <= PTR_RST;
            ptr[c]     <= PTR_RST;
            rld[c]     <= CNT_RST;
            cnt[c]     <= CNT_RST;
         end else begin
            pin_q[c] <= external_interrupt_pin[c];
            // Set wins over both clears
            req[c] <= hit[c] |
                      (req[c] & ~take &
                       ~(wctl & ~pwdata[CT_REQ]));
            if (take & fresh[c]) begin
               ptr[c] <= base_p;
               cnt[c] <= rld[c];
            end
            if (take)
               fresh[c] <= 1'b0;
            if (fin) begin
               ptr[c] <= ptr[c] + (w_unit8 ? INC8 : INC16);
               if (cnt[c] == CNT_RST)
                  en[c] <= 1'b0;
               else
                  cnt[c] <= cnt[c] - 16'h0001;
            end
            if (wr_acc & wsel(paddr, 1'(c), OFS_SRC))
               src_r[c] <= pwdata[19:0];
            if (wr_acc & wsel(paddr, 1'(c), OFS_DST))
               dst_r[c] <= pwdata[19:0];
            if (wr_acc & wsel(paddr, 1'(c), OFS_RLD))
               rld[c] <= pwdata[15:0];
            // Writing one again restarts the channel, even mid-run
            if (wctl) begin
               en[c]      <= pwdata[CT_EN];
               fresh[c]   <= pwdata[CT_EN] | fresh[c];
               unit8[c]   <= pwdata[CT_UNIT8];
               fwd_dst[c] <= pwdata[CT_FWDDST];
               sel[c]     <= pwdata[CT_SEL+:SEL_W];
            end
         end
      end
   end

   // ****************************************************************
   // Transfer sequencer
   // ****************************************************************
   always_comb begin
      next_state = state;
      case (state)
         S_IDLE:  if (start) next_state = S_RD;
         S_RD:    if (adv) next_state = src2 ? S_RD2 : S_WR;
         S_RD2:   if (adv) next_state = S_WR;
         S_WR:    if (adv) next_state = dst2 ? S_WR2 : S_DUMMY;
         S_WR2:   if (adv) next_state = S_DUMMY;
         S_DUMMY: next_state = S_CPU;
         S_CPU:   if (cpu_done) next_state = S_IDLE;
         default: next_state = S_IDLE;
      endcase
   end

   always_comb begin
      case (next_state)
         S_RD:    next_addr = a_src;
         S_RD2:   next_addr = a_src + INC8;
         S_WR:    next_addr = a_dst;
         S_WR2:   next_addr = a_dst + INC8;
         default: next_addr = PTR_RST;
      endcase
      case (next_state)
         S_WR: next_wdata = state == S_WR ? bus_wdata :
                            (dst2 ? {8'h00, rd_word[7:0]} : rd_word);
         S_WR2: next_wdata = state == S_WR2 ? bus_wdata :
                             {8'h00, data[15:8]};
         default: next_wdata = 16'h0000;
      endcase
   end

   wire next_byte = (next_state == S_RD && (a_u8 | src2)) ||
                    (next_state == S_WR && (a_u8 | dst2)) ||
                    next_state == S_RD2 || next_state == S_WR2;

   assign bus_own = state != S_IDLE && state != S_CPU;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= S_IDLE;
         wt        <= 1'b0;
         ch        <= 1'b0;
         data      <= 16'h0000;
         w_src     <= PTR_RST;
         w_dst     <= PTR_RST;
         w_unit8   <= 1'b0;
         bus_addr  <= PTR_RST;
         bus_rd    <= 1'b0;
         bus_wr    <= 1'b0;
         bus_byte  <= 1'b0;
         bus_wdata <= 16'h0000;
      end else begin
         state     <= next_state;
         wt        <= busy & bus_slow & ~wt;
         bus_addr  <= next_addr;
         bus_rd    <= next_state inside {S_RD, S_RD2};
         bus_wr    <= next_state inside {S_WR, S_WR2};
         bus_byte  <= next_byte;
         bus_wdata <= next_wdata;
         if ((state == S_RD || state == S_RD2) && adv)
            data <= rd_word;
         if (start) begin
            ch      <= pick;
            w_src   <= st_src;
            w_dst   <= st_dst;
            w_unit8 <= unit8[pick];
         end
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking dcb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_read_then_write;
      (state == S_RD && adv && !src2) |=> state == S_WR && bus_wr;
   endproperty
   a_read_then_write: assert property (p_read_then_write)
      else $error("read not followed by write");

   property p_odd_two_reads;
      (state == S_RD && adv && src2) |=>
         state == S_RD2 && bus_byte && bus_addr == $past(w_src) + INC8;
   endproperty
   a_odd_two_reads: assert property (p_odd_two_reads)
      else $error("odd 16-bit source lacks second read");

   property p_wait_stretch;
      (busy && bus_slow && !wt) |=> $stable(bus_addr) && state == $past(state);
   endproperty
   a_wait_stretch: assert property (p_wait_stretch)
      else $error("waited cycle not stretched");

   property p_reload;
      (start && fresh[pick]) |=> cnt[ch] == rld[ch] && ptr[ch] == $past(base_p);
   endproperty
   a_reload: assert property (p_reload)
      else $error("reload missing at first transfer");

   property p_req_set;
      (|hit) |=> (req & $past(hit)) == $past(hit);
   endproperty
   a_req_set: assert property (p_req_set)
      else $error("request bit not set by its source");

   property p_req_clear;
      (start && !hit[pick]) |=> !req[ch];
   endproperty
   a_req_clear: assert property (p_req_clear)
      else $error("request not cleared at start");
   property p_sw_clear;
      (wr_acc && wsel(paddr, 1'b0, OFS_CTRL) && !pwdata[CT_REQ] && !hit[0])
         |=> !req[0];
   endproperty
   a_sw_clear: assert property (p_sw_clear)
      else $error("software clear of request failed");
   property p_priority;
      (state == S_IDLE && go[0] && go[1]) |=> ch == 1'b0 && state == S_RD;
   endproperty
   a_priority: assert property (p_priority)
      else $error("channel zero not served first");
   property p_dummy_release;
      (state == S_DUMMY) |=> state == S_CPU && !bus_own && !bus_rd && !bus_wr;
   endproperty
   a_dummy_release: assert property (p_dummy_release)
      else $error("bus not released after dummy cycle");
   property p_swreq_reads_zero;
      (psel && !penable && !pwrite && paddr[4:0] == OFS_CTRL)
         |=> !prdata[CT_SWREQ];
   endproperty
   a_swreq_reads_zero: assert property (p_swreq_reads_zero)
      else $error("software request bit read as one");

   c_both: cover property (state == S_IDLE && go[0] && go[1]);
   c_odd16: cover property (state == S_WR2);
   c_slow: cover property (busy && bus_slow && !wt);
   c_restart: cover property (state != S_IDLE && fresh[ch]);

endmodule

//--- verif/dmc_cpu_model.sv
// CPU core and memory model on the far side of the internal bus.
// Assumes the DMA drives registered bus signals and owns the bus per bus_own.
`timescale 1ns/1ns
module dmc_cpu_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        bus_own,
   input  wire logic [19:0] bus_addr,
   input  wire logic        bus_rd,
   input  wire logic        bus_wr,
   input  wire logic        bus_byte,
   input  wire logic [15:0] bus_wdata,
   input  wire logic [1:0]  cpu_lat,
   output logic      [15:0] bus_rdata,
   output logic             bus_slow,
   output logic             cpu_done
);
   // ****************************************************************
   // Memory and statistics
   // ****************************************************************
   logic [7:0]  mem [int];
   int          rd_cnt, wr_cnt, cyc_cnt, dmy_cnt, cpu_cnt;
   int          log_a[$], log_c[$];
   logic        own_d, rd_d, wr_d, pend;
   logic [19:0] a_d;
   logic [1:0]  wt;
   logic [15:0] cyc;

   function automatic logic [7:0] rd8(input logic [19:0] a);
      return mem.exists(int'(a)) ? mem[int'(a)] : (a[7:0] ^ 8'h5A);
   endfunction

   // Upper half of the map is the waited area
   assign bus_slow = bus_addr[19];

   // Idle data lanes toggle so a stale sample never looks valid
   always @* begin
      if (bus_rd && bus_byte)
         bus_rdata = {8'h00, rd8(bus_addr)};
      else if (bus_rd)
         bus_rdata = {rd8(bus_addr + 20'h00001), rd8(bus_addr)};
      else
         bus_rdata = {cyc[7:0], ~cyc[7:0]};
   end

   // ****************************************************************
   // Bus observation and CPU access
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {rd_cnt, wr_cnt, cyc_cnt, dmy_cnt, cpu_cnt} = '0;
         {own_d, rd_d, wr_d, pend, a_d, wt, cyc} = '0;
         cpu_done <= 1'b0;
      end else begin
         cyc = cyc + 16'h0001;
         if (bus_rd && (!rd_d || bus_addr != a_d))
            rd_cnt++;
         if (bus_wr && (!wr_d || bus_addr != a_d)) begin
            wr_cnt++;
            log_a.push_back(int'(bus_addr));
            log_c.push_back(cpu_cnt);
            mem[int'(bus_addr)] = bus_wdata[7:0];
            if (!bus_byte)
               mem[int'(bus_addr) + 1] = bus_wdata[15:8];
         end
         if (bus_rd || bus_wr)
            cyc_cnt++;
         if (bus_own && !bus_rd && !bus_wr)
            dmy_cnt++;
         cpu_done <= 1'b0;
         // One access per hand-back, then the bus is returned
         if (own_d && !bus_own) begin
            pend = 1'b1;
            wt   = cpu_lat;
         end else if (pend && wt == 2'd0) begin
            cpu_done <= 1'b1;
            pend = 1'b0;
            cpu_cnt++;
         end else if (pend)
            wt = wt - 2'd1;
         own_d = bus_own;
         rd_d  = bus_rd;
         wr_d  = bus_wr;
         a_d   = bus_addr;
      end
   end
endmodule

//--- verif/dmc_top_tb.sv
// Self-checking bench for the two-channel DMA block.
// Assumes an APB zero-wait slave and the CPU model on the internal bus.
`timescale 1ns/1ns
module dmc_top_tb
   import dmc_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        bus_own, bus_rd, bus_wr, bus_byte, bus_slow, cpu_done;
   logic [1:0]  pin, lat;
   logic [13:0] pev;
   logic [15:0] bus_rdata, bus_wdata;
   logic [19:0] bus_addr;
   int          error_cnt, compares, cycles, c, r0, w0, y0, d0;
   localparam logic [31:0] EN = 32'h1 << CT_EN, U8 = 32'h1 << CT_UNIT8;
   localparam logic [31:0] FD = 32'h1 << CT_FWDDST, RQ = 32'h1 << CT_REQ;
   localparam logic [31:0] SW = 32'h1 << CT_SWREQ;

   dmc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_interrupt_pin(pin), .periph_evt(pev),
      .bus_rdata(bus_rdata), .bus_slow(bus_slow), .cpu_done(cpu_done),
      .bus_own(bus_own), .bus_addr(bus_addr), .bus_rd(bus_rd),
      .bus_wr(bus_wr), .bus_byte(bus_byte), .bus_wdata(bus_wdata));
   dmc_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .bus_own(bus_own),
      .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
      .bus_byte(bus_byte), .bus_wdata(bus_wdata), .cpu_lat(lat),
      .bus_rdata(bus_rdata), .bus_slow(bus_slow), .cpu_done(cpu_done));

   // ****************************************************************
   // Tasks
   // ****************************************************************
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task automatic end_sim;
      $display("compares=%0d errors=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Long enough for every test with slow CPU hand-back
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         end_sim;
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [7:0] ra(input int ch, input logic [4:0] o);
      return {2'b00, ch[0], o};
   endfunction
   task automatic setch(input int ch, input logic [31:0] s,
                        input logic [31:0] d, input logic [31:0] n);
      apb(1'b1, ra(ch, OFS_SRC), s);
      apb(1'b1, ra(ch, OFS_DST), d);
      apb(1'b1, ra(ch, OFS_RLD), n);
   endtask
   task automatic pin_pulse(input logic [1:0] m);
      @(posedge pclk);
      pin <= ~m;
      repeat (2) @(posedge pclk);
      pin <= 2'b11;
   endtask
   task automatic settle(input int nwr);
      for (int k = 0; k < 300 && (u_cpu.wr_cnt < nwr || bus_own
           || u_cpu.pend || u_cpu.own_d); k++) @(posedge pclk);
      repeat (3) @(posedge pclk);
   endtask
   task automatic snap;
      r0 = u_cpu.rd_cnt; w0 = u_cpu.wr_cnt;
      y0 = u_cpu.cyc_cnt; d0 = u_cpu.dmy_cnt;
   endtask

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      pin = 2'b11; pev = 0; lat = 0; presetn = 0; cycles = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ra(0, OFS_CTRL), 0); chk(rd, 0);
      apb(1'b0, ra(1, OFS_CNT), 0); chk(rd, {16'h0, CNT_RST});
      apb(1'b0, ra(1, OFS_PTR), 0); chk(rd, {12'h0, PTR_RST});
      apb(1'b0, 8'h18, 0); chk({31'h0, err}, 1); chk(rd, 0);
      $display("test reset done");
      apb(1'b1, ra(0, OFS_CTRL), 0);
      apb(1'b1, ra(1, OFS_CTRL), 0);
      pin_pulse(2'b11);
      apb(1'b0, ra(0, OFS_CTRL), 0); chk(rd & RQ, RQ);
      apb(1'b0, ra(1, OFS_CTRL), 0); chk(rd & RQ, RQ);
      apb(1'b1, ra(0, OFS_CTRL), RQ);
      apb(1'b0, ra(0, OFS_CTRL), 0); chk(rd & RQ, RQ);
      apb(1'b1, ra(0, OFS_CTRL), 0);
      apb(1'b0, ra(0, OFS_CTRL), 0); chk(rd & RQ, 0);
      for (c = 2; c < 16; c++) begin
         apb(1'b1, ra(0, OFS_CTRL), c << CT_SEL);
         @(posedge pclk); pev <= 14'h1 << (c - 2);
         @(posedge pclk); pev <= '0;
         apb(1'b0, ra(0, OFS_CTRL), 0); chk(rd & 32'hF08, (c << 8) | RQ);
      end
      apb(1'b1, ra(0, OFS_CTRL), 0);
      apb(1'b1, ra(1, OFS_CTRL), 0);
      $display("test request done");
      setch(0, 32'h00100, 32'h00200, 0); snap;
      // Software trigger only counts once the selection already stands
      apb(1'b1, ra(0, OFS_CTRL), 32'(SRC_SW) << CT_SEL);
      apb(1'b1, ra(0, OFS_CTRL), EN | U8 | SW | (SRC_SW << CT_SEL));
      settle(w0 + 1);
      chk(u_cpu.mem[32'h200], pat(20'h00100));
      chk(u_cpu.rd_cnt - r0, 1); chk(u_cpu.wr_cnt - w0, 1);
      chk(u_cpu.cyc_cnt - y0, 2);
      chk(u_cpu.dmy_cnt - d0, 1);
      apb(1'b0, ra(0, OFS_CTRL), 0); chk(rd & (EN | RQ | SW), 0);
      $display("test byte unit done");
      setch(0, 32'h80101, 32'h00301, 0); snap;
      apb(1'b1, ra(0, OFS_CTRL), EN | FD | SW | (SRC_SW << CT_SEL));
      settle(w0 + 2);
      chk(u_cpu.rd_cnt - r0, 2); chk(u_cpu.wr_cnt - w0, 2);
      chk(u_cpu.cyc_cnt - y0, 6);
      chk(u_cpu.mem[32'h301], pat(20'h80101));
      chk(u_cpu.mem[32'h302], pat(20'h80102));
      apb(1'b0, ra(0, OFS_PTR), 0); chk(rd, 32'h00303);
      $display("test odd word done");
      setch(0, 32'h00800, 32'h00900, 0);
      snap;
      apb(1'b1, ra(0, OFS_CTRL), EN | SW | (SRC_SW << CT_SEL));
      settle(w0 + 1);
      chk(u_cpu.mem[32'h900], pat(20'h00800));
      chk(u_cpu.mem[32'h901], pat(20'h00801));
      chk(u_cpu.rd_cnt - r0, 1);
      chk(u_cpu.wr_cnt - w0, 1);
      chk(u_cpu.cyc_cnt - y0, 2);
      $display("test even word done");
      lat <= 2'd2;
      setch(1, 32'h00400, 32'h00500, 3); snap;
      apb(1'b1, ra(1, OFS_CTRL), EN | U8);
      pin_pulse(2'b10); settle(w0 + 1);
      pin_pulse(2'b10); settle(w0 + 2);
      apb(1'b0, ra(1, OFS_PTR), 0); chk(rd, 32'h00402);
      apb(1'b0, ra(1, OFS_CNT), 0); chk(rd, 1);
      apb(1'b1, ra(1, OFS_CTRL), EN | U8);
      pin_pulse(2'b10); settle(w0 + 3);
      apb(1'b0, ra(1, OFS_PTR), 0); chk(rd, 32'h00401);
      apb(1'b0, ra(1, OFS_CNT), 0); chk(rd, 2);
      apb(1'b1, ra(1, OFS_CTRL), 0);
      $display("test reload done");
      lat <= 2'd3;
      setch(0, 32'h00600, 32'h00700, 0);
      setch(1, 32'h00610, 32'h00710, 0);
      apb(1'b1, ra(0, OFS_CTRL), EN | U8);
      apb(1'b1, ra(1, OFS_CTRL), EN | U8);
      u_cpu.log_a.delete(); u_cpu.log_c.delete(); snap;
      pin_pulse(2'b11); settle(w0 + 2);
      chk(u_cpu.log_a.size(), 2);
      chk(u_cpu.log_a[0], 32'h700); chk(u_cpu.log_a[1], 32'h710);
      chk(u_cpu.log_c[1] - u_cpu.log_c[0], 1);
      $display("test priority done");
      end_sim;
   end
   function automatic logic [7:0] pat(input logic [19:0] a);
      return a[7:0] ^ 8'h5A;
   endfunction
endmodule
